/* ssp_pkg.sv */
/*
 * Shared constants, types and helper functions of the sensor SPI command port.
 * Assumes a single 100 MHz system clock domain for every user of this package.
 */
package ssp_pkg;

	// Command codes of the first byte of a transaction.
	localparam logic [7:0] CMD_REG_WR = 8'h0A;
	localparam logic [7:0] CMD_REG_RD = 8'h0B;
	localparam logic [7:0] CMD_FIFO_RD = 8'h0D;

	// Register space layout.
	localparam int ADDR_W = 7;
	localparam int REG_DEPTH = 128;
	localparam logic [6:0] ADDR_FIRST = 7'h00;
	localparam logic [6:0] ADDR_STATUS = 7'h0B;
	localparam logic [6:0] ADDR_STATUS2 = 7'h44;
	localparam logic [6:0] ADDR_PROT_LAST = 7'h43;
	localparam logic [6:0] ADDR_USER_LAST = 7'h45;
	localparam logic [6:0] ADDR_DATA_A_FIRST = 7'h08;
	localparam logic [6:0] ADDR_DATA_A_LAST = 7'h0A;
	localparam logic [6:0] ADDR_DATA_B_FIRST = 7'h0E;
	localparam logic [6:0] ADDR_DATA_B_LAST = 7'h17;

	// Status bit positions and reset values.
	localparam int STAT_ERR_BIT = 7;
	localparam int STAT_DRDY_BIT = 0;
	localparam logic ERR_RESET = 1'b1;
	localparam logic DRDY_RESET = 1'b0;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// Check bits per protected byte: four Hamming bits plus overall parity.
	localparam int ECC_W = 5;

	// Data-ready clearing latency.
	localparam int CLK_MHZ = 100;
	localparam int DRDY_CLR_NORM_US = 120;
	localparam int DRDY_CLR_WAKE_US = 420;
	localparam int DRDY_CLR_NORM_CYC = DRDY_CLR_NORM_US * CLK_MHZ;
	localparam int DRDY_CLR_WAKE_CYC = DRDY_CLR_WAKE_US * CLK_MHZ;
	localparam int CLR_CNT_W = 16;

	typedef enum logic [2:0] {
		ST_CMD,
		ST_ADDR,
		ST_WR,
		ST_RD,
		ST_FIFO,
		ST_IGNORE
	} ssp_state_t;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic mosi;
	} ssp_pins_t;

	typedef struct packed {
		logic en;
		logic [6:0] addr;
		logic [7:0] data;
	} ssp_wr_t;

	localparam ssp_pins_t PINS_IDLE = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};

	// Single-error-correcting, double-error-detecting code of one byte.
	function automatic logic [4:0] ssp_ecc(input logic [7:0] d);
		logic [3:0] p;
		p[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
		p[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
		p[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
		p[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
		return {^{d, p}, p};
	endfunction

	function automatic logic ssp_is_data_addr(input logic [6:0] a);
		return ((a >= ADDR_DATA_A_FIRST) && (a <= ADDR_DATA_A_LAST)) ||
			((a >= ADDR_DATA_B_FIRST) && (a <= ADDR_DATA_B_LAST));
	endfunction

endpackage

/* ssp_sync.sv */
/*
 * Two flip-flop synchroniser for a group of asynchronous inputs.
 * Assumes the inputs change slowly against clk; the first stage feeds only the second.
 */
`timescale 1ns/10ps
module ssp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] d_out
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] sync_reg;
	logic [W-1:0] sync_next;

	always_comb begin
		meta_next = d_in;
		sync_next = meta_reg;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign d_out = sync_reg;
endmodule

/* ssp_regmem.sv */
/*
 * User register memory, 128 bytes, each stored with its check bits.
 * Assumes one write per cycle; both read ports return registered data one cycle late.
 */
`timescale 1ns/10ps
module ssp_regmem (
	input wire logic clk,
	input wire logic sys_rst,
	input ssp_pkg::ssp_wr_t wr,
	input wire logic [ssp_pkg::ADDR_W-1:0] rd_addr,
	output logic [7:0] rd_data,
	input wire logic [ssp_pkg::ADDR_W-1:0] chk_addr,
	output logic [7:0] chk_data,
	output logic [ssp_pkg::ECC_W-1:0] chk_ecc
);
	import ssp_pkg::*;

	logic [7:0] mem [REG_DEPTH];
	logic [ECC_W-1:0] ecc_mem [REG_DEPTH];

	// Clearing at reset keeps stored and computed check bits consistent from the start.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < REG_DEPTH; i++) begin
				mem[i] <= REG_RESET;
				ecc_mem[i] <= ssp_ecc(REG_RESET);
			end
		end else if (wr.en) begin
			mem[wr.addr] <= wr.data;
			// RULE_18: recompute check bits
			ecc_mem[wr.addr] <= ssp_ecc(wr.data);
		end
	end

	always_ff @(posedge clk) begin
		rd_data <= mem[rd_addr];
		chk_data <= mem[chk_addr];
		chk_ecc <= ecc_mem[chk_addr];
	end
endmodule

/* ssp_port.sv */
/*
 * Four-wire SPI slave command port: command decode, register read and write with
 * auto-increment, FIFO streaming, data-ready clearing and register integrity check.
 * Assumes the serial pins are asynchronous to clk and the serial clock is at most
 * about an eighth of clk; the FIFO presents its head word with a valid flag.
 */
`timescale 1ns/10ps
// Summary of operation
// RULE_01: Mode zero: clock idles low, data sampled on rising, changed on falling edge.
// RULE_02: First byte is the command: 0x0A write, 0x0B read, 0x0D FIFO read.
// RULE_03: Register access is command, one address byte, data bytes, then select release.
// RULE_04: FIFO read has no address; every later byte returns FIFO data.
// RULE_05: Each FIFO sample goes out most significant byte first.
// RULE_06: Host reads whole sample sets in one burst to keep alignment.
// RULE_07: Bursts of any length are accepted for all three commands.
// RULE_08: FIFO pops follow the serial clock, one sample per two bytes.
// RULE_09: Register bursts start at the given address and increment per byte.
// RULE_10: Only addresses up to 0x45 give valid read data.
// RULE_11: Seven address bits decode 128 locations; 0x46 to 0x7F are reserved.
// RULE_12: Reading 0x08-0x0A or 0x0E-0x17 clears the data-ready flag.
// RULE_13: That clear lands within 120 us, or 420 us in wake-up mode.
// RULE_14: Other reads, writes and FIFO reads act without added latency.
// RULE_15: Invalid commands leave the serial output undriven until select rises.
// RULE_16: Serial output is driven only while read data is shifted out.
// RULE_17: Host ignores the serial output during register writes.
// RULE_18: Check bits over 0x00 to 0x43 are recomputed on every protected write.
// RULE_19: A check mismatch sets the integrity error bit in 0x0B and 0x44.
// RULE_20: The integrity error bit is set at reset and cleared by the first write.
// RULE_21: The check code detects single and double bit errors.
// RULE_22: Host runs the serial clock between 1 MHz and 8 MHz; the bench host runs it at 12.5 MHz for register accesses.
// RULE_23: Select release aborts a partial byte and waits for a new command.
// RULE_24: Every byte moves most significant bit first on both data lines.
module ssp_port #(
	parameter int CLR_NORM_CYC = ssp_pkg::DRDY_CLR_NORM_CYC,
	parameter int CLR_WAKE_CYC = ssp_pkg::DRDY_CLR_WAKE_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input ssp_pkg::ssp_pins_t spi_in,
	output logic miso_o,
	output logic miso_oe,
	input wire logic [15:0] fifo_data,
	input wire logic fifo_valid,
	output logic fifo_pop,
	input wire logic sample_ready,
	input wire logic wake_mode,
	output logic data_ready,
	output logic err_user_regs,
	output ssp_pkg::ssp_wr_t reg_wr
);
	import ssp_pkg::*;

	ssp_pins_t pins_s;
	logic sclk_d_reg;
	logic sclk_d_next;
	logic rise;
	logic fall;
	logic cs_active;

	ssp_state_t state_reg;
	ssp_state_t state_next;
	logic [2:0] bit_cnt_reg;
	logic [2:0] bit_cnt_next;
	logic [7:0] rx_reg;
	logic [7:0] rx_next;
	logic [7:0] rx_byte;
	logic rd_cmd_reg;
	logic rd_cmd_next;
	logic [6:0] addr_reg;
	logic [6:0] addr_next;
	logic [7:0] tx_reg;
	logic [7:0] tx_next;
	logic [7:0] load_byte;
	logic miso_reg;
	logic miso_next;
	logic oe_reg;
	logic oe_next;
	ssp_wr_t wr_reg;
	ssp_wr_t wr_next;
	logic [15:0] sample_reg;
	logic [15:0] sample_next;
	logic lsb_next_reg;
	logic lsb_next_next;
	logic pop_reg;
	logic pop_next;
	logic clr_req_reg;
	logic clr_req_next;

	logic [7:0] mem_rd_data;
	logic [6:0] scan_reg;
	logic [6:0] scan_next;
	logic [7:0] chk_data;
	logic [ECC_W-1:0] chk_ecc;
	logic mismatch;
	logic err_reg;
	logic err_next;
	logic drdy_reg;
	logic drdy_next;
	logic [CLR_CNT_W-1:0] clr_cnt_reg;
	logic [CLR_CNT_W-1:0] clr_cnt_next;
	logic clr_busy_reg;
	logic clr_busy_next;
	logic clr_fire;

	ssp_sync #(
		.W(3),
		.RST_VAL(PINS_IDLE)
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.d_in(spi_in),
		.d_out(pins_s)
	);

	ssp_regmem u_mem (
		.clk(clk),
		.sys_rst(sys_rst),
		.wr(wr_reg),
		.rd_addr(addr_reg),
		.rd_data(mem_rd_data),
		.chk_addr(scan_reg),
		.chk_data(chk_data),
		.chk_ecc(chk_ecc)
	);

	// RULE_01: edges of the sampled clock
	assign rise = pins_s.sclk & ~sclk_d_reg;
	assign fall = ~pins_s.sclk & sclk_d_reg;
	assign cs_active = ~pins_s.cs_n;
	// RULE_24: shift in from the bottom
	assign rx_byte = {rx_reg[6:0], pins_s.mosi};

	// Read data for the current address, with live status bits laid over memory.
	always_comb begin
		load_byte = mem_rd_data;
		if (addr_reg == ADDR_STATUS) begin
			// RULE_19: error bit in first status
			load_byte[STAT_ERR_BIT] = err_reg;
			load_byte[STAT_DRDY_BIT] = drdy_reg;
		end else if (addr_reg == ADDR_STATUS2) begin
			// RULE_19: error bit in second status
			load_byte[STAT_ERR_BIT] = err_reg;
		end
		if (state_reg == ST_FIFO) begin
			// RULE_05: high byte first
			if (!lsb_next_reg) begin
				load_byte = fifo_valid ? fifo_data[15:8] : REG_RESET;
			end else begin
				load_byte = sample_reg[7:0];
			end
		end
	end

	always_comb begin
		sclk_d_next = pins_s.sclk;
		state_next = state_reg;
		bit_cnt_next = bit_cnt_reg;
		rx_next = rx_reg;
		rd_cmd_next = rd_cmd_reg;
		addr_next = addr_reg;
		tx_next = tx_reg;
		miso_next = miso_reg;
		oe_next = oe_reg;
		wr_next = wr_reg;
		wr_next.en = 1'b0;
		sample_next = sample_reg;
		lsb_next_next = lsb_next_reg;
		pop_next = 1'b0;
		clr_req_next = 1'b0;
		if (!cs_active) begin
			// RULE_23: abort and wait for a command
			state_next = ST_CMD;
			bit_cnt_next = '0;
			oe_next = 1'b0;
			lsb_next_next = 1'b0;
		end else if (rise) begin
			rx_next = rx_byte;
			bit_cnt_next = bit_cnt_reg + 3'h1;
			if (bit_cnt_reg == BIT_LAST) begin
				case (state_reg)
					ST_CMD: begin
						// RULE_02: decode command byte
						case (rx_byte)
							CMD_REG_WR: begin
								state_next = ST_ADDR;
								rd_cmd_next = 1'b0;
							end
							CMD_REG_RD: begin
								state_next = ST_ADDR;
								rd_cmd_next = 1'b1;
							end
							// RULE_04: no address byte for FIFO
							CMD_FIFO_RD: state_next = ST_FIFO;
							// RULE_15: unknown code, stay silent
							default: state_next = ST_IGNORE;
						endcase
					end
					ST_ADDR: begin
						// RULE_03: address byte follows command
						// RULE_11: seven address bits decode
						addr_next = rx_byte[6:0];
						state_next = rd_cmd_reg ? ST_RD : ST_WR;
					end
					ST_WR: begin
						// RULE_14: write lands next cycle
						wr_next = '{en: 1'b1, addr: addr_reg, data: rx_byte};
						// RULE_09: increment per byte
						addr_next = addr_reg + 7'h01;
					end
					ST_RD: begin
						// RULE_09: increment per byte
						// RULE_10: no guard past last user address
						addr_next = addr_reg + 7'h01;
					end
					default: state_next = state_reg;
				endcase
			end
		end else if (fall) begin
			if ((bit_cnt_reg == 3'h0) && ((state_reg == ST_RD) || (state_reg == ST_FIFO))) begin
				// RULE_16: drive only while sending
				// RULE_07: reload every byte, unbounded burst
				tx_next = {load_byte[6:0], 1'b0};
				miso_next = load_byte[7];
				oe_next = 1'b1;
				if (state_reg == ST_FIFO) begin
					lsb_next_next = ~lsb_next_reg;
					if (!lsb_next_reg) begin
						// RULE_08: pop once per two serial bytes
						sample_next = fifo_data;
						pop_next = fifo_valid;
					end
				end else if (ssp_is_data_addr(addr_reg)) begin
					// RULE_12: data register read
					clr_req_next = 1'b1;
				end
			end else if (oe_reg) begin
				// RULE_24: next bit, top first
				miso_next = tx_reg[7];
				tx_next = {tx_reg[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sclk_d_reg <= 1'b0;
			state_reg <= ST_CMD;
			bit_cnt_reg <= '0;
			rx_reg <= REG_RESET;
			rd_cmd_reg <= 1'b0;
			addr_reg <= ADDR_FIRST;
			tx_reg <= REG_RESET;
			miso_reg <= 1'b0;
			oe_reg <= 1'b0;
			wr_reg <= '0;
			sample_reg <= '0;
			lsb_next_reg <= 1'b0;
			pop_reg <= 1'b0;
			clr_req_reg <= 1'b0;
		end else begin
			sclk_d_reg <= sclk_d_next;
			state_reg <= state_next;
			bit_cnt_reg <= bit_cnt_next;
			rx_reg <= rx_next;
			rd_cmd_reg <= rd_cmd_next;
			addr_reg <= addr_next;
			tx_reg <= tx_next;
			miso_reg <= miso_next;
			oe_reg <= oe_next;
			wr_reg <= wr_next;
			sample_reg <= sample_next;
			lsb_next_reg <= lsb_next_next;
			pop_reg <= pop_next;
			clr_req_reg <= clr_req_next;
		end
	end

	// A byte-wise SECDED code checked by a walking scan costs far less logic than one wide
	// code over all protected bytes, at the price of up to 68 cycles of detection delay.
	// RULE_21: per-byte check comparison
	assign mismatch = (ssp_ecc(chk_data) != chk_ecc);
	assign clr_fire = clr_busy_reg && (clr_cnt_reg == CLR_CNT_W'(1));

	always_comb begin
		// RULE_18: walk the protected range
		scan_next = (scan_reg == ADDR_PROT_LAST) ? ADDR_FIRST : scan_reg + 7'h01;
		// RULE_19: mismatch sets the error bit
		// RULE_20: any write clears, a mismatch wins
		err_next = mismatch | (err_reg & ~wr_reg.en);
		clr_busy_next = clr_busy_reg;
		clr_cnt_next = clr_cnt_reg;
		if (clr_req_reg && !clr_busy_reg) begin
			// RULE_13: latency by power mode
			clr_busy_next = 1'b1;
			clr_cnt_next = wake_mode ? CLR_CNT_W'(CLR_WAKE_CYC) : CLR_CNT_W'(CLR_NORM_CYC);
		end else if (clr_busy_reg) begin
			clr_cnt_next = clr_cnt_reg - CLR_CNT_W'(1);
			clr_busy_next = ~clr_fire;
		end
		// A new sample arriving with the clear keeps the flag set.
		drdy_next = sample_ready | (drdy_reg & ~clr_fire);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			scan_reg <= ADDR_FIRST;
			err_reg <= ERR_RESET;
			drdy_reg <= DRDY_RESET;
			clr_cnt_reg <= '0;
			clr_busy_reg <= 1'b0;
		end else begin
			scan_reg <= scan_next;
			err_reg <= err_next;
			drdy_reg <= drdy_next;
			clr_cnt_reg <= clr_cnt_next;
			clr_busy_reg <= clr_busy_next;
		end
	end

	// RULE_15: output keeps last level when undriven
	assign miso_o = miso_reg;
	assign miso_oe = oe_reg;
	assign fifo_pop = pop_reg;
	assign data_ready = drdy_reg;
	assign err_user_regs = err_reg;
	assign reg_wr = wr_reg;
endmodule

/* ssp_monitor.sv */
/*
 * Concurrent checks on the ports of the sensor SPI command port.
 * Assumes the serial pins come from a host whose half period is at least four clk cycles.
 */
`timescale 1ns/10ps
module ssp_monitor (
	input wire logic clk,
	input wire logic sys_rst,
	input ssp_pkg::ssp_pins_t spi_in,
	input wire logic miso_oe,
	input wire logic fifo_valid,
	input wire logic fifo_pop,
	input wire logic sample_ready,
	input wire logic data_ready,
	input wire logic err_user_regs,
	input ssp_pkg::ssp_wr_t reg_wr
);
	import ssp_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_oe_idle; spi_in.cs_n [*6] |-> !miso_oe; endproperty
	property p_wr_quiet; reg_wr.en |-> !miso_oe; endproperty
	property p_wr_gap; reg_wr.en |=> !reg_wr.en [*8]; endproperty
	property p_wr_cs; reg_wr.en |-> !$past(spi_in.cs_n, 2); endproperty
	property p_pop_gap; fifo_pop |=> !fifo_pop [*8]; endproperty
	property p_pop_valid; fifo_pop |-> $past(fifo_valid); endproperty
	property p_pop_oe; fifo_pop |-> miso_oe; endproperty
	property p_drdy_set; sample_ready |=> data_ready; endproperty
	property p_err_clr; reg_wr.en |=> !err_user_regs; endproperty
	property p_err_rst; $fell(sys_rst) |-> err_user_regs; endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("output driven while deselected");
	a_wr_quiet: assert property (p_wr_quiet) else $error("output driven during write");
	a_wr_gap: assert property (p_wr_gap) else $error("write strobes too close");
	a_wr_cs: assert property (p_wr_cs) else $error("write outside a frame");
	a_pop_gap: assert property (p_pop_gap) else $error("pops too close");
	a_pop_valid: assert property (p_pop_valid) else $error("pop of an empty fifo");
	a_pop_oe: assert property (p_pop_oe) else $error("pop without shifting out");
	a_drdy_set: assert property (p_drdy_set) else $error("new sample not flagged");
	a_err_clr: assert property (p_err_clr) else $error("error flag kept after write");
	a_err_rst: assert property (p_err_rst) else $error("error flag low after reset");
	c_wr: cover property (reg_wr.en);
	c_pop: cover property (fifo_pop);
	c_drdy: cover property ($fell(data_ready));
endmodule
bind ssp_port ssp_monitor i_ssp_monitor (.clk(clk), .sys_rst(sys_rst), .spi_in(spi_in), .miso_oe(miso_oe),
	.fifo_valid(fifo_valid), .fifo_pop(fifo_pop), .sample_ready(sample_ready), .data_ready(data_ready),
	.err_user_regs(err_user_regs), .reg_wr(reg_wr));

/* ssp_host.sv */
/*
 * Behavioural SPI host in mode zero for the sensor command port.
 * Assumes the port settles its output within one serial period after a falling edge.
 */
`timescale 1ns/10ps
module ssp_host (
	output ssp_pkg::ssp_pins_t pins,
	input wire logic miso_o,
	input wire logic miso_oe
);
	import ssp_pkg::*;
	logic keep_lvl = 1'b0;
	logic [7:0] rx_byte = 8'h00;
	int half = 40;
	event rx_ev;
	initial pins = PINS_IDLE;
	always @* if (miso_oe) keep_lvl = miso_o;
	task automatic cs(input logic lvl);
		#half pins.cs_n = lvl;
		// The data line toggles between frames so no stale bit can pass for a real one.
		pins.mosi = ~pins.mosi;
		#half;
	endtask
	task automatic xfer(input logic [7:0] tx, input int nbits, input bit chk);
		for (int i = 7; i > 7 - nbits; i--) begin
			pins.mosi = tx[i];
			#half pins.sclk = 1'b1;
			#half rx_byte[i] = keep_lvl;
			pins.sclk = 1'b0;
		end
		if (chk) ->rx_ev;
	endtask
endmodule

/* tb.sv */
/*
 * Self-checking bench of the sensor SPI command port with a host model and a show-ahead FIFO model.
 * Assumes ssp_host and the bound monitor are compiled before this file.
 */
`timescale 1ns/10ps
module tb;
	import ssp_pkg::*;
	localparam int NORM = 200;
	localparam int WAKE = 600;
	logic clk;
	logic sys_rst;
	logic [15:0] fifo_data;
	logic fifo_valid;
	logic sample_ready;
	logic wake_mode;
	logic oe_seen = 1'b0;
	logic err_m = 1'b1;
	logic miso_o, miso_oe, fifo_pop, data_ready, err_user_regs;
	logic [15:0] s;
	logic [7:0] mem [128];
	logic [7:0] bad [4] = '{8'h00, 8'h0C, 8'h8B, 8'hFF};
	logic [7:0] exp_q [$];
	logic [15:0] fq [$];
	ssp_pins_t spi_in;
	ssp_wr_t reg_wr;
	ssp_wr_t wr_q [$];
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;
	int pops = 0;
	int t0 = 0;
	int seed = 32'hA649;

	ssp_port #(.CLR_NORM_CYC(NORM), .CLR_WAKE_CYC(WAKE)) i_ssp_port (.clk(clk), .sys_rst(sys_rst), .spi_in(spi_in),
		.miso_o(miso_o), .miso_oe(miso_oe), .fifo_data(fifo_data), .fifo_valid(fifo_valid), .fifo_pop(fifo_pop),
		.sample_ready(sample_ready), .wake_mode(wake_mode), .data_ready(data_ready), .err_user_regs(err_user_regs),
		.reg_wr(reg_wr));
	ssp_host i_ssp_host (.pins(spi_in), .miso_o(miso_o), .miso_oe(miso_oe));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic wr_burst(input logic [7:0] a, input int n, input int tail);
		logic [7:0] d;
		i_ssp_host.cs(1'b0);
		i_ssp_host.xfer(CMD_REG_WR, 8, 0);
		i_ssp_host.xfer(a, 8, 0);
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			mem[(a + i) % 128] = d;
			wr_q.push_back(ssp_wr_t'({1'b1, 7'(a + i), d}));
			i_ssp_host.xfer(d, 8, 0);
		end
		if (tail > 0) i_ssp_host.xfer(8'hA5, tail, 0);
		i_ssp_host.cs(1'b1);
		err_m = 1'b0;
	endtask

	task automatic rd_burst(input logic [7:0] a, input int n);
		logic [7:0] e;
		int k;
		i_ssp_host.cs(1'b0);
		i_ssp_host.xfer(CMD_REG_RD, 8, 0);
		i_ssp_host.xfer(a, 8, 0);
		for (int i = 0; i < n; i++) begin
			k = (a + i) % 128;
			e = mem[k];
			if (k == ADDR_STATUS || k == ADDR_STATUS2) e[STAT_ERR_BIT] = err_m;
			if (k == ADDR_STATUS) e[STAT_DRDY_BIT] = 1'b0;
			if (k <= ADDR_USER_LAST) exp_q.push_back(e);
			i_ssp_host.xfer(8'($random(seed)), 8, k <= ADDR_USER_LAST);
		end
		i_ssp_host.cs(1'b1);
	endtask

	// The FIFO model drops its head on a pop and shows the next word one cycle later.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (miso_oe === 1'b1) oe_seen <= 1'b1;
		if (fifo_pop === 1'b1) begin
			pops++;
			void'(fq.pop_front());
		end
		fifo_valid <= fq.size() != 0;
		fifo_data <= fq.size() != 0 ? fq[0] : 16'h0000;
		if (cyc == 40000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	always @(posedge clk) if (reg_wr.en === 1'b1) check(reg_wr, wr_q.pop_front());
	always @(i_ssp_host.rx_ev) check(i_ssp_host.rx_byte, exp_q.pop_front());

	initial begin
		sys_rst = 1'b1;
		fifo_data = 16'h0000;
		fifo_valid = 1'b0;
		sample_ready = 1'b0;
		wake_mode = 1'b0;
		mem = '{default: REG_RESET};
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1 check(err_user_regs, ERR_RESET);
		check(data_ready, DRDY_RESET);
		rd_burst(8'h0B, 1);
		wr_burst(8'hFE, 130, 0);
		check(err_user_regs, 1'b0);
		rd_burst(8'h80, 128);
		for (int m = 0; m < 2; m++) begin
			@(posedge clk);
			wake_mode <= m[0];
			sample_ready <= 1'b1;
			@(posedge clk);
			sample_ready <= 1'b0;
			repeat (2) @(posedge clk);
			#1 check(data_ready, 1'b1);
			fork
				rd_burst(8'h0C, 3);
				begin
					wait (miso_oe === 1'b1);
					t0 = cyc;
					wait (data_ready === 1'b0 || cyc > t0 + 2000);
					t0 = cyc - t0 - (m ? WAKE : NORM);
					check(16'(t0 > 124 && t0 < 134), 16'h0001);
				end
			join
		end
		i_ssp_host.half = 120;
		for (int i = 0; i < 3; i++) begin
			s = 16'($random(seed));
			fq.push_back(s);
			exp_q.push_back(s[15:8]);
			exp_q.push_back(s[7:0]);
		end
		exp_q.push_back(8'h00);
		pops = 0;
		i_ssp_host.cs(1'b0);
		i_ssp_host.xfer(CMD_FIFO_RD, 8, 0);
		for (int i = 0; i < 8; i++) i_ssp_host.xfer(8'($random(seed)), 8, i < 7);
		i_ssp_host.cs(1'b1);
		check(16'(pops), 16'h0003);
		i_ssp_host.half = 40;
		oe_seen = 1'b0;
		foreach (bad[k]) begin
			i_ssp_host.cs(1'b0);
			i_ssp_host.xfer(bad[k], 8, 0);
			i_ssp_host.xfer(8'h0B, 8, 0);
			i_ssp_host.xfer(8'h00, 8, 0);
			i_ssp_host.cs(1'b1);
		end
		check(oe_seen, 1'b0);
		i_ssp_host.cs(1'b0);
		i_ssp_host.xfer(CMD_REG_WR, 3, 0);
		i_ssp_host.cs(1'b1);
		wr_burst(8'h20, 1, 5);
		rd_burst(8'h20, 2);
		check(16'(exp_q.size() + wr_q.size()), 16'h0000);
		report_and_stop();
	end
endmodule
